// file: bps_far_end.sv
// Purpose: far-side event source for the status bench
// Assumes: fire is held for one cycle
// Notes: each fire gives a one-cycle event pulse
`timescale 1ns/1ns
module bps_far_end
   import bps_pkg::*;
(
   // Clock and command
   input wire logic aclk,
   input wire logic fire,
   input wire logic rev_kind,
   input wire logic [7:0] mask,
   // Event pulses
   output bps_fwd_ev_t fwd_ev,
   output bps_rev_ev_t rev_ev
);
   always_ff @(posedge aclk) begin
      fwd_ev <= (fire && !rev_kind) ? mask[6:0] : 7'h0;
      rev_ev <= (fire && rev_kind) ? mask : 8'h0;
   end
endmodule

// file: bps_pkg.sv
// Purpose: constants and types for the bridge primary status half-word
// Assumes: register word at byte offset 0x04, status in bits 31:16
// Notes: reserved bits read as zero
//
// What this block does
// - Bit 19 reflects pending legacy interrupt request
// - Bit 20 always one, capability list exists
// - Bit 21 one in reverse, zero forward
// - Bit 23 one only reverse conventional PCI
// - Forward: poisoned completion or poisoned write sets 24
// - Reverse: read data parity error sets 24
// - Reverse: parity error signal on send sets 24
// - Reverse: split completion parity message sets 24
// - Bits 26:25 read 00 forward, 01 reverse
// - Forward: completer abort sent sets bit 27
// - Reverse: target abort as target sets 27
// - Forward: completer abort completion received sets 28
// - Reverse: target abort seen as master sets 28
// - Forward: unsupported request completion sets bit 29
// - Reverse: master abort detected sets bit 29
// - Forward: error message sent sets bit 30
// - Reverse: system error driven sets bit 30
// - Forward: poisoned packet received sets bit 31
// - Reverse: address or data parity sets 31
// - Error flags clear by writing one only
// - Bit 24 needs parity error response enable
package bps_pkg;
   localparam logic [7:0] BPS_STATUS_OFS = 8'h04;
   localparam logic [7:0] BPS_CTRL_OFS = 8'h40;
   localparam logic [7:0] BPS_CAP_PTR = 8'h34;
   localparam int BPS_INTX_BIT = 19;
   localparam int BPS_CAP_BIT = 20;
   localparam int BPS_66M_BIT = 21;
   localparam int BPS_FBB_BIT = 23;
   localparam int BPS_MDPE_BIT = 24;
   localparam int BPS_DEVSEL_LO = 25;
   localparam int BPS_STA_BIT = 27;
   localparam int BPS_RTA_BIT = 28;
   localparam int BPS_RMA_BIT = 29;
   localparam int BPS_SSE_BIT = 30;
   localparam int BPS_DPE_BIT = 31;
   localparam int BPS_PERR_EN_BIT = 6;
   localparam logic [1:0] BPS_DEVSEL_FWD = 2'h0;
   localparam logic [1:0] BPS_DEVSEL_REV = 2'h1;
   localparam logic [1:0] BPS_RESP_OKAY = 2'h0;
   localparam logic [1:0] BPS_RESP_SLVERR = 2'h2;
   localparam logic [31:0] BPS_FLAG_MASK = 32'hf9000000;

   // Forward-mode (link) events
   typedef struct packed {
      logic poisoned_cpl_rx;
      logic poisoned_wr_tx;
      logic ca_cpl_tx;
      logic ca_cpl_rx;
      logic ur_cpl_rx;
      logic err_msg_tx;
      logic poisoned_tlp_rx;
   } bps_fwd_ev_t;

   // Reverse-mode (parallel bus) events
   typedef struct packed {
      logic rd_data_perr;
      logic perr_on_write;
      logic split_msg_perr;
      logic target_abort_tx;
      logic target_abort_rx;
      logic master_abort;
      logic serr_driven;
      logic addr_data_perr;
   } bps_rev_ev_t;
endpackage

// file: bps_status.sv
// Purpose: primary status half-word with AXI4-Lite access
// Assumes: event inputs are one-cycle pulses synchronous to aclk
// Notes: word 0x04 holds command bits in 15:0 (only bit 6 stored here)
`timescale 1ns/1ns
module bps_status
   import bps_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Mode straps and state
   input wire logic reverse_mode,
   input wire logic pci_conventional,
   input wire logic intx_pending,
   // Events
   input wire bps_fwd_ev_t fwd_ev,
   input wire bps_rev_ev_t rev_ev,
   // Observed enable and status copy
   output logic parity_resp_en,
   output logic [31:0] status_word,
   // AXI4-Lite write
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic [31:0] clr_mask;
   logic [5:0] flags;
   logic [5:0] set_ev;
   logic [31:0] ro_word;

   assign s_awready = !aw_held && !s_bvalid;
   assign s_wready = !w_held && !s_bvalid;
   assign wr_fire = aw_held && w_held && !s_bvalid;
   assign s_arready = !s_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_awvalid && s_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (s_wvalid && s_wready) begin
         w_held <= 1'b1;
         w_data <= s_wdata;
         w_strb <= s_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_bvalid <= 1'b0;
         s_bresp <= BPS_RESP_OKAY;
      end else if (wr_fire) begin
         s_bvalid <= 1'b1;
         s_bresp <= (aw_addr[7:2] == BPS_STATUS_OFS[7:2]) ? BPS_RESP_OKAY : BPS_RESP_SLVERR;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   // Parity error response enable lives in the command half
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         parity_resp_en <= 1'b0;
      end else if (wr_fire && aw_addr[7:2] == BPS_STATUS_OFS[7:2] && w_strb[0]) begin
         parity_resp_en <= w_data[BPS_PERR_EN_BIT];
      end
   end

   // Byte-lane gated write-one-to-clear mask
   always_comb begin
      clr_mask = 32'h00000000;
      if (wr_fire && aw_addr[7:2] == BPS_STATUS_OFS[7:2]) begin
         clr_mask = w_data & {{8{w_strb[3]}}, {8{w_strb[2]}}, 16'h0000} & BPS_FLAG_MASK;
      end
   end

   // Events per flag: mdpe, sta, rta, rma, sse, dpe
   always_comb begin
      if (reverse_mode) begin
         set_ev[0] = parity_resp_en && (rev_ev.rd_data_perr
                     || rev_ev.perr_on_write
                     || rev_ev.split_msg_perr);
         set_ev[1] = rev_ev.target_abort_tx;
         set_ev[2] = rev_ev.target_abort_rx;
         set_ev[3] = rev_ev.master_abort;
         set_ev[4] = rev_ev.serr_driven;
         set_ev[5] = rev_ev.addr_data_perr;
      end else begin
         set_ev[0] = parity_resp_en && (fwd_ev.poisoned_cpl_rx || fwd_ev.poisoned_wr_tx);
         set_ev[1] = fwd_ev.ca_cpl_tx;
         set_ev[2] = fwd_ev.ca_cpl_rx;
         set_ev[3] = fwd_ev.ur_cpl_rx;
         set_ev[4] = fwd_ev.err_msg_tx;
         set_ev[5] = fwd_ev.poisoned_tlp_rx;
      end
   end

   // Sticky flags; a set in the clearing cycle wins
   genvar gi;
   for (gi = 0; gi < 6; gi++) begin : g_flag
      localparam int BITPOS = (gi == 0) ? BPS_MDPE_BIT : BPS_STA_BIT + gi - 1;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            flags[gi] <= 1'b0;
         end else if (set_ev[gi]) begin
            flags[gi] <= 1'b1;
         end else if (clr_mask[BITPOS]) begin
            flags[gi] <= 1'b0;
         end
      end
   end

   always_comb begin
      ro_word = 32'h00000000;
      ro_word[BPS_PERR_EN_BIT] = parity_resp_en;
      ro_word[BPS_INTX_BIT] = intx_pending;
      ro_word[BPS_CAP_BIT] = 1'b1;
      ro_word[BPS_66M_BIT] = reverse_mode;
      ro_word[BPS_FBB_BIT] = reverse_mode && pci_conventional;
      ro_word[BPS_DEVSEL_LO +: 2] = reverse_mode ? BPS_DEVSEL_REV : BPS_DEVSEL_FWD;
      ro_word[BPS_MDPE_BIT] = flags[0];
      ro_word[BPS_DPE_BIT:BPS_STA_BIT] = flags[5:1];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_word <= 32'h00000000;
      end else begin
         status_word <= ro_word;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h00000000;
         s_rresp <= BPS_RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         if (s_araddr[7:2] == BPS_STATUS_OFS[7:2]) begin
            s_rdata <= ro_word;
            s_rresp <= BPS_RESP_OKAY;
         end else begin
            s_rdata <= 32'h00000000;
            s_rresp <= BPS_RESP_SLVERR;
         end
      end else if (s_rready) begin
         s_rvalid <= 1'b0;
      end
   end

   sequence s_clear_write(int b);
      wr_fire && clr_mask[b];
   endsequence

   a_cap_always_one: assert property (@(posedge aclk) disable iff (!aresetn)
      status_word[BPS_CAP_BIT] == 1'b1 || $past(!aresetn))
      else $error("capability bit not one");
   a_devsel_by_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      ro_word[26:25] == (reverse_mode ? 2'h1 : 2'h0))
      else $error("device select timing wrong");
   a_66m_by_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      ro_word[BPS_66M_BIT] == reverse_mode)
      else $error("66 MHz bit wrong");
   a_fbb_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      !reverse_mode |-> !ro_word[BPS_FBB_BIT])
      else $error("fast back-to-back set in forward mode");
   a_intx_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      ro_word[BPS_INTX_BIT] == intx_pending)
      else $error("interrupt pending bit wrong");
   a_mdpe_gated: assert property (@(posedge aclk) disable iff (!aresetn)
      !parity_resp_en && !flags[0] |=> !flags[0])
      else $error("parity flag set while disabled");
   a_sta_set: assert property (@(posedge aclk) disable iff (!aresetn)
      !reverse_mode && fwd_ev.ca_cpl_tx |=> ro_word[BPS_STA_BIT])
      else $error("signaled target abort not set");
   a_dpe_set: assert property (@(posedge aclk) disable iff (!aresetn)
      reverse_mode && rev_ev.addr_data_perr |=> ro_word[BPS_DPE_BIT])
      else $error("detected parity error not set");
   a_sse_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      s_clear_write(BPS_SSE_BIT) ##0 !set_ev[4] |=> !flags[4])
      else $error("system error flag not cleared");
   a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      ro_word[18:16] == 3'h0 && !ro_word[22])
      else $error("reserved bits nonzero");

   // One event of the mode that is currently selected
   sequence s_fwd_hit(ev);
      !reverse_mode && ev;
   endsequence

   sequence s_rev_hit(ev);
      reverse_mode && ev;
   endsequence

   // Set conditions, forward mode
   a_mdpe_fwd_cpl: assert property (@(posedge aclk) disable iff (!aresetn)
      s_fwd_hit(parity_resp_en && fwd_ev.poisoned_cpl_rx) |=> flags[0])
      else $error("parity flag missed poisoned completion");

   a_mdpe_fwd_wr: assert property (@(posedge aclk) disable iff (!aresetn)
      s_fwd_hit(parity_resp_en && fwd_ev.poisoned_wr_tx) |=> flags[0])
      else $error("parity flag missed poisoned write");

   a_rta_fwd_set: assert property (@(posedge aclk) disable iff (!aresetn)
      s_fwd_hit(fwd_ev.ca_cpl_rx) |=> flags[2])
      else $error("received target abort not set");

   a_rma_fwd_set: assert property (@(posedge aclk) disable iff (!aresetn)
      s_fwd_hit(fwd_ev.ur_cpl_rx) |=> flags[3])
      else $error("received master abort not set");

   a_sse_fwd_set: assert property (@(posedge aclk) disable iff (!aresetn)
      s_fwd_hit(fwd_ev.err_msg_tx) |=> flags[4])
      else $error("signaled system error not set");

   a_dpe_fwd_set: assert property (@(posedge aclk) disable iff (!aresetn)
      s_fwd_hit(fwd_ev.poisoned_tlp_rx) |=> flags[5])
      else $error("detected parity error missed poisoned packet");

   // Set conditions, reverse mode
   a_mdpe_rev_rd: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rev_hit(parity_resp_en && rev_ev.rd_data_perr) |=> flags[0])
      else $error("parity flag missed read data error");

   a_mdpe_rev_wr: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rev_hit(parity_resp_en && rev_ev.perr_on_write) |=> flags[0])
      else $error("parity flag missed write parity signal");

   a_mdpe_rev_msg: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rev_hit(parity_resp_en && rev_ev.split_msg_perr) |=> flags[0])
      else $error("parity flag missed split message");

   a_sta_rev_set: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rev_hit(rev_ev.target_abort_tx) |=> flags[1])
      else $error("signaled target abort not set");

   a_rta_rev_set: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rev_hit(rev_ev.target_abort_rx) |=> flags[2])
      else $error("received target abort not set");

   a_rma_rev_set: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rev_hit(rev_ev.master_abort) |=> flags[3])
      else $error("received master abort not set");

   a_sse_rev_set: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rev_hit(rev_ev.serr_driven) |=> flags[4])
      else $error("signaled system error not set");

   a_fbb_rev: assert property (@(posedge aclk) disable iff (!aresetn)
      reverse_mode |-> ro_word[BPS_FBB_BIT] == pci_conventional)
      else $error("fast back-to-back bit wrong");

   // Write-one-to-clear per flag, unless a set arrives together
   a_mdpe_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      s_clear_write(BPS_MDPE_BIT) ##0 !set_ev[0] |=> !flags[0])
      else $error("parity flag not cleared");

   a_sta_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      s_clear_write(BPS_STA_BIT) ##0 !set_ev[1] |=> !flags[1])
      else $error("signaled target abort not cleared");

   a_rta_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      s_clear_write(BPS_RTA_BIT) ##0 !set_ev[2] |=> !flags[2])
      else $error("received target abort not cleared");

   a_rma_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      s_clear_write(BPS_RMA_BIT) ##0 !set_ev[3] |=> !flags[3])
      else $error("received master abort not cleared");

   a_dpe_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      s_clear_write(BPS_DPE_BIT) ##0 !set_ev[5] |=> !flags[5])
      else $error("detected parity error not cleared");

   a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
      set_ev[4] |=> flags[4])
      else $error("system error set lost to clear");

   a_flags_steady: assert property (@(posedge aclk) disable iff (!aresetn)
      !(|set_ev) && !wr_fire |=> $stable(flags))
      else $error("flags changed without cause");

   a_flags_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(!aresetn) |-> flags == 6'h00 && !parity_resp_en)
      else $error("flags not zero after reset");

   // Register copy and bus behaviour
   a_status_copy: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> status_word == $past(ro_word))
      else $error("status copy out of step");

   a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_arvalid && s_arready && s_araddr[7:2] != BPS_STATUS_OFS[7:2]
      |=> s_rresp == BPS_RESP_SLVERR && s_rdata == 32'h00000000)
      else $error("unmapped read not refused");

   a_write_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
      s_bvalid |-> !s_awready && !s_wready)
      else $error("write accepted while response pending");

   a_read_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rvalid |-> !s_arready)
      else $error("read accepted while data pending");

   a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write response dropped early");

   a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read data dropped early");
endmodule

// file: bridge_primary_status_register_test.sv
// Purpose: register tests of the primary status word
// Assumes: AXI4-Lite master tasks, events from bps_far_end
// Notes: expected words built from mode inputs
`timescale 1ns/1ns
module bridge_primary_status_register_test
   import bps_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, rv = 1'b0, cv = 1'b0, ix = 1'b0;
   logic fire = 1'b0, kind = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] mask = 8'h0, awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rd, rdata, sw;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] rsp, bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, pe_out;
   bps_fwd_ev_t fev;
   bps_rev_ev_t rev;
   int num_errors = 0, n_tests = 0, cycles = 0;
   int fmap[7] = '{31, 30, 29, 28, 27, 24, 24};
   int rmap[8] = '{31, 30, 29, 28, 27, 24, 24, 24};
   always #4 aclk = ~aclk;
   bps_far_end far_u (.aclk(aclk), .fire(fire), .rev_kind(kind), .mask(mask),
      .fwd_ev(fev), .rev_ev(rev));
   bps_status dut_u (.aclk(aclk), .aresetn(aresetn), .reverse_mode(rv),
      .pci_conventional(cv), .intx_pending(ix), .fwd_ev(fev), .rev_ev(rev),
      .parity_resp_en(pe_out), .status_word(sw), .s_awaddr(awaddr),
      .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
      .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
      .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
      .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
      .s_rready(rready));
   function logic [31:0] stat(input logic r, c, i, p);
      stat = {6'h0, r, 1'b0, r & c, 1'b0, r, 1'b1, i, 12'h0, p, 6'h0};
   endfunction
   task chk(input logic [31:0] seen, exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && awready === 1'b1) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   // Pulse lands one edge after the fire edge
   task ev(input logic k, input logic [7:0] m);
      @(posedge aclk);
      fire <= 1'b1;
      kind <= k;
      mask <= m;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axr(8'h04);
      chk(rd, stat(0, 0, 0, 0), "reset word");
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         {rv, cv, ix} <= k[2:0];
         axr(8'h04);
         chk(rd, stat(k[2], k[1], k[0], 0), "mode bits");
         chk(sw, stat(k[2], k[1], k[0], 0), "status copy");
         chk({30'h0, rsp}, {30'h0, BPS_RESP_OKAY}, "read resp");
      end
      $display("test mode bits done");
      cv <= 1'b0;
      ix <= 1'b0;
      axw(8'h04, 32'h40, 4'h1);
      chk({31'h0, pe_out}, 32'h1, "parity enable");
      chk({30'h0, rsp}, {30'h0, BPS_RESP_OKAY}, "write resp");
      for (int m = 0; m < 2; m++) begin
         rv <= m[0];
         for (int i = 0; i < 7 + m; i++) begin
            ev(m[0], 8'h1 << i);
            axr(8'h04);
            chk(rd, stat(m[0], 0, 0, 1) | (32'h1 << (m ? rmap[i] : fmap[i])),
               "flag set");
            axw(8'h04, 32'h40, 4'hf);
            axr(8'h04);
            chk(rd, stat(m[0], 0, 0, 1) | (32'h1 << (m ? rmap[i] : fmap[i])),
               "flag kept");
            axw(8'h04, 32'hffff_ffff, 4'hf);
            axr(8'h04);
            chk(rd, stat(m[0], 0, 0, 1), "flag cleared");
         end
      end
      $display("test flags done");
      ev(1'b0, 8'h7f);
      axr(8'h04);
      chk(rd, stat(1, 0, 0, 1), "other mode ignored");
      axw(8'h04, 32'h0, 4'h1);
      ev(1'b1, 8'he0);
      axr(8'h04);
      chk(rd, stat(1, 0, 0, 0), "parity gated");
      $display("test gating done");
      axw(8'h08, 32'hffff_ffff, 4'hf);
      chk({30'h0, rsp}, {30'h0, BPS_RESP_SLVERR}, "unmapped write");
      axr(8'h08);
      chk({30'h0, rsp}, {30'h0, BPS_RESP_SLVERR}, "unmapped resp");
      chk(rd, 32'h0, "unmapped data");
      $display("test unmapped done");
      conclude();
   end
endmodule
